// file: dv/i2csr_engine_model.sv
// Behavioural model of the bus engine and pins beside the registers
`timescale 1ns/1ps
`default_nettype none
module i2csr_engine_model (
  input wire logic ref_clk,
  output wire logic rx_char_valid,
  output wire logic [7:0] rx_char_data,
  output wire logic tx_load,
  output wire logic start_det,
  output wire logic stop_det,
  output wire logic nack_det,
  output wire logic arb_lost_det,
  output wire logic gen_call_det,
  output wire logic master_mode,
  output wire logic addr_10bit,
  output wire logic scl_in,
  output wire logic inst1_transmit_flag,
  output wire logic inst1_receive_flag
);
  // Order: rx, tx load, start, stop, nack, arb lost, general call
  logic [6:0] ev_r = 7'h00;
  // Master, 10-bit, clock pin (pulled up), second-instance flags
  logic [4:0] lv_r = 5'h04;
  logic [7:0] d_r = 8'h00;
  assign {rx_char_valid, tx_load, start_det, stop_det, nack_det,
    arb_lost_det, gen_call_det} = ev_r;
  assign {master_mode, addr_10bit, scl_in, inst1_transmit_flag,
    inst1_receive_flag} = lv_r;
  assign rx_char_data = d_r;
  task pulse(input logic [6:0] e, input logic [7:0] d);
    @(posedge ref_clk);
    ev_r <= e;
    d_r <= d;
    @(posedge ref_clk);
    ev_r <= 7'h00;
    // Scrambled so that stale data cannot pass as valid
    d_r <= ~d;
  endtask
  task levels(input logic [4:0] l);
    @(posedge ref_clk);
    lv_r <= l;
  endtask
endmodule // i2csr_engine_model
`default_nettype wire

// file: dv/i2csr_props.sv
// Port-level assertions for the bus handshake, buffer and target address registers
`timescale 1ns/1ps
`default_nettype none
`include "i2csr_defs.vh"
module i2csr_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic tx_load,
  input wire logic master_mode,
  input wire logic addr_10bit,
  input wire logic [7:0] tx_data,
  input wire logic tx_pending,
  input wire logic [9:0] target_addr_out,
  input wire logic target_addr_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Shadow of the last character handed over by the shifter
  logic [7:0] last_rx_r;
  wire tx_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address == `I2CSR_OFF_TXBUF;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) last_rx_r <= 8'h00;
    else if (rx_char_valid) last_rx_r <= rx_char_data;
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // A character landing in the read cycle itself is left out
  sequence s_rx_rd;
    s_req ##0 avs_read && !rx_char_valid
      && avs_address == `I2CSR_OFF_RXBUF;
  endsequence
  a_wait_one_cycle: assert property (s_req |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait state count off");
  a_rx_latest_char: assert property (s_rx_rd |=> avs_readdata[7:0] == $past(last_rx_r)) else $error("stale receive data");
  a_tx_write_held: assert property (tx_wr |=> tx_pending && tx_data == $past(avs_writedata[7:0])) else $error("transmit byte lost");
  a_tx_hold_stable: assert property (tx_pending && !tx_load && !tx_wr |=> tx_pending && $stable(tx_data)) else $error("transmit byte moved");
  a_tx_load_empty: assert property (tx_load && !tx_wr |=> !tx_pending) else $error("buffer not emptied");
  a_addr_slave_off: assert property (!master_mode |=> target_addr_out == 10'h000 && !target_addr_valid) else $error("address used as slave");
  a_addr_master_on: assert property (master_mode |=> target_addr_valid) else $error("address not offered");
  a_addr_seven_bit: assert property (master_mode && !addr_10bit |=> target_addr_out[9:7] == 3'h0) else $error("upper bits leaked");
endmodule // i2csr_props
bind i2csr_regs i2csr_props u_props (.*);
`default_nettype wire

// file: dv/i2csr_regs_tb_top.sv
// Self-checking bench for the status, buffer and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`include "i2csr_defs.vh"
module i2csr_regs_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, rx_char_valid, tx_load, start_det, stop_det;
  wire nack_det, arb_lost_det, gen_call_det, master_mode, addr_10bit;
  wire scl_in, inst1_transmit_flag, inst1_receive_flag;
  wire [7:0] rx_char_data, tx_data;
  wire tx_pending, target_addr_valid, irq;
  wire [9:0] target_addr_out;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h2a;
  logic [31:0] q, v;
  logic [6:0] evs [6] = '{7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h10};
  logic [7:0] sts [6] = '{8'h12, 8'h04, 8'h0c, 8'h0d, 8'h2d, 8'h13};
  i2csr_regs DUT (.*);
  i2csr_engine_model u_eng (.*);
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_ta(logic [9:0] a, logic m, logic w);
    if (!m) return 32'h0;
    return w ? {22'h0, a} : {25'h0, a[6:0]};
  endfunction
  task complete_run();
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task wt(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_mismatch++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask
  task irq_is(input logic e);
    wt(2);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset values, the last address unmapped
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 6'(i * 4), 32'h0);
      chk(q, (i == 6) ? 32'h8 : 32'h0);
    end
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      bus(1'b0, `I2CSR_OFF_TXBUF, {24'h0, v[7:0]});
      wt(1);
      chk({23'h0, tx_pending, tx_data}, {23'h1, v[7:0]});
      bus(1'b1, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO, 32'h0);
      chk(q, 32'h0);
      u_eng.pulse(7'h20, 8'h00);
      u_eng.pulse(7'h40, v[15:8]);
      wt(1);
      chk({31'h0, tx_pending}, 32'h0);
      bus(1'b1, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO, 32'h0);
      chk(q, 32'hc);
      bus(1'b1, `I2CSR_OFF_RXBUF, 32'h0);
      chk(q, {24'h0, v[15:8]});
      bus(1'b1, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO, 32'h0);
      chk(q, 32'h8);
    end
    // Back-to-back characters: only the newest is kept
    u_eng.pulse(7'h40, 8'h5a);
    u_eng.pulse(7'h40, 8'ha5);
    bus(1'b1, `I2CSR_OFF_RXBUF, 32'h0);
    chk(q, 32'ha5);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      u_eng.levels({i[0], i[1], 3'h4});
      bus(1'b0, `I2CSR_OFF_TADDR, v);
      bus(1'b1, `I2CSR_OFF_TADDR, 32'h0);
      chk(q, {22'h0, v[9:0]});
      wt(1);
      chk({22'h0, target_addr_out}, exp_ta(v[9:0], i[0], i[1]));
      chk({31'h0, target_addr_valid}, {31'h0, i[0]});
    end
    u_eng.levels(5'h04);
    irq_is(1'b0);
    bus(1'b0, `I2CSR_OFF_IE2, 32'h08);
    irq_is(1'b1);
    bus(1'b0, `I2CSR_OFF_TXBUF, 32'h33);
    irq_is(1'b0);
    u_eng.pulse(7'h20, 8'h00);
    bus(1'b0, `I2CSR_OFF_IE2, 32'h04);
    irq_is(1'b0);
    u_eng.pulse(7'h40, 8'h77);
    irq_is(1'b1);
    bus(1'b1, `I2CSR_OFF_RXBUF, 32'h0);
    irq_is(1'b0);
    bus(1'b0, `I2CSR_OFF_IE2, 32'h00);
    bus(1'b0, `I2CSR_OFF_EVT_EN, 32'h0f);
    // Start, stop, nack, arbitration, general call, start again
    for (int i = 0; i < 6; i++) begin
      u_eng.pulse(evs[i], 8'h00);
      bus(1'b1, `I2CSR_OFF_STATUS, 32'h0);
      chk(q, {24'h0, sts[i]});
      irq_is(1'b1);
    end
    // Read-only bits survive a clear of everything
    bus(1'b0, `I2CSR_OFF_STATUS, 32'hff);
    bus(1'b1, `I2CSR_OFF_STATUS, 32'h0);
    chk(q, 32'h10);
    irq_is(1'b0);
    bus(1'b0, `I2CSR_OFF_EVT_EN, 32'h0e);
    u_eng.pulse(7'h02, 8'h00);
    irq_is(1'b0);
    // Second-instance flag gated by its own enable
    u_eng.levels(5'h06);
    irq_is(1'b0);
    bus(1'b0, `I2CSR_OFF_IE1, 32'h08);
    irq_is(1'b1);
    bus(1'b0, `I2CSR_OFF_IE1, 32'h00);
    irq_is(1'b0);
    u_eng.levels(5'h00);
    wt(6);
    bus(1'b1, `I2CSR_OFF_STATUS, 32'h0);
    chk(q, 32'h51);
    // Flag register clears by writing ones
    u_eng.pulse(7'h40, 8'h3c);
    bus(1'b1, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO, 32'h0);
    chk(q, 32'hc);
    bus(1'b0, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO, 32'h0c);
    bus(1'b1, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO, 32'h0);
    chk(q, 32'h0);
    complete_run();
  end
endmodule // i2csr_regs_tb_top
`default_nettype wire

// file: pkg/i2csr_defs.vh
// Constants for the serial status, buffer and interrupt register block
`ifndef I2CSR_DEFS_VH
`define I2CSR_DEFS_VH

// Register byte offsets
`define I2CSR_OFF_STATUS 6'h00
`define I2CSR_OFF_RXBUF 6'h04
`define I2CSR_OFF_TXBUF 6'h08
`define I2CSR_OFF_TADDR 6'h0c
`define I2CSR_OFF_EVT_EN 6'h10
`define I2CSR_OFF_IE2 6'h14
`define I2CSR_OFF_SHARED_IRQ_FLAG_TWO 6'h18
`define I2CSR_OFF_IE1 6'h1c

// Bus status field positions
`define I2CSR_ST_ARB 0
`define I2CSR_ST_STT 1
`define I2CSR_ST_STP 2
`define I2CSR_ST_NACK 3
`define I2CSR_ST_BUSY 4
`define I2CSR_ST_GC 5
`define I2CSR_ST_SCLLOW 6
`define I2CSR_ST_UNUSED 7
// Software-clearable event flags in the status register
`define I2CSR_ST_EVT_MASK 8'h2f
// Event enables live in the low nibble
`define I2CSR_EVT_EN_MASK 8'h0f

// Shared flag / enable fields
`define I2CSR_TX_BIT 3
`define I2CSR_RX_BIT 2

// Target address layout
`define I2CSR_TADDR_MSB 9
`define I2CSR_TADDR7_MSB 6
`define I2CSR_TADDR_MASK 16'h03ff
// Upper address byte keeps only bits 9 and 8
`define I2CSR_TADDR_HI_MASK 8'h03

// Reset values
`define I2CSR_RST_STATUS 8'h00
`define I2CSR_RST_EVT_EN 8'h00
`define I2CSR_RST_IE 8'h00
`define I2CSR_RST_TXFLAG 1'b1
`define I2CSR_RST_RXFLAG 1'b0
`define I2CSR_RST_BYTE 8'h00
`define I2CSR_RST_TADDR 16'h0000

`endif

// file: rtl/i2csr_regs.v
// Status, data buffer, target address and interrupt registers of the link
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "i2csr_defs.vh"

module i2csr_regs (
  input wire ref_clk,
  input wire rstn,
  // Avalon-MM slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Bus engine events, same clock
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire tx_load,
  input wire start_det,
  input wire stop_det,
  input wire nack_det,
  input wire arb_lost_det,
  input wire gen_call_det,
  input wire master_mode,
  input wire addr_10bit,
  // Flags of the second instance
  input wire inst1_transmit_flag,
  input wire inst1_receive_flag,
  // Clock line pin level
  input wire scl_in,
  // Engine side outputs
  output wire [7:0] tx_data,
  output wire tx_pending,
  output wire [9:0] target_addr_out,
  output wire target_addr_valid,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg wait_r;
  reg [31:0] rdata_r;
  reg [7:0] status_r;
  reg [7:0] status_nxt;
  reg [7:0] rxbuf_r;
  reg [7:0] txbuf_r;
  reg tx_full_r;
  reg [15:0] taddr_r;
  reg [7:0] evt_en_r;
  reg [7:0] ie2_r;
  reg [7:0] ie1_r;
  reg tx_flag_r;
  reg rx_flag_r;
  reg [9:0] taddr_out_r;
  reg taddr_valid_r;
  reg irq_r;
  reg [31:0] rdata_nxt;
  reg irq_nxt;

  wire scl_sync;
  wire acc_go;
  wire wr_go;
  wire rd_go;
  wire [7:0] wbyte0;
  wire [7:0] wbyte1;
  wire [7:0] shared_irq_flag_two_view;
  wire [7:0] ie1_flags;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Matches a byte address against a register offset
  function hit;
    input [5:0] addr;
    input [5:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Write-one-to-clear with hardware set winning over the clear
  function [7:0] w1c_set;
    input [7:0] cur;
    input [7:0] clr;
    input [7:0] set;
    begin
      w1c_set = (cur & ~clr) | set;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  i2csr_sync #(
    .WIDTH(1)
  ) u_scl_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(scl_in),
    .sync_out(scl_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  // One wait cycle per access: decode on the first edge, act on the second,
  // so a write and its side effects land exactly when waitrequest is low.

  assign acc_go = (avs_read | avs_write) & ~wait_r;
  assign wr_go = avs_write & ~wait_r;
  assign rd_go = avs_read & ~wait_r;
  assign wbyte0 = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
  assign wbyte1 = avs_byteenable[1] ? avs_writedata[15:8] : 8'h00;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_r <= 1'b1;
    end else if (acc_go) begin
      wait_r <= 1'b1;
    end else if (avs_read | avs_write) begin
      wait_r <= 1'b0;
    end
  end

  assign shared_irq_flag_two_view = {4'h0, tx_flag_r, rx_flag_r, 2'b00};
  assign ie1_flags = {4'h0, inst1_transmit_flag, inst1_receive_flag, 2'b00};

  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit(avs_address, `I2CSR_OFF_STATUS)) begin
      rdata_nxt[7:0] = status_r;
    end else if (hit(avs_address, `I2CSR_OFF_RXBUF)) begin
      rdata_nxt[7:0] = rxbuf_r;
    end else if (hit(avs_address, `I2CSR_OFF_TXBUF)) begin
      rdata_nxt[7:0] = txbuf_r;
    end else if (hit(avs_address, `I2CSR_OFF_TADDR)) begin
      rdata_nxt[15:0] = taddr_r;
    end else if (hit(avs_address, `I2CSR_OFF_EVT_EN)) begin
      rdata_nxt[7:0] = evt_en_r;
    end else if (hit(avs_address, `I2CSR_OFF_IE2)) begin
      rdata_nxt[7:0] = ie2_r;
    end else if (hit(avs_address, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO)) begin
      rdata_nxt[7:0] = shared_irq_flag_two_view;
    end else if (hit(avs_address, `I2CSR_OFF_IE1)) begin
      rdata_nxt[7:0] = ie1_r;
    end
  end

  // Unmapped reads return zero; data is latched before waitrequest drops
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read & wait_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus status flags

  always @* begin
    status_nxt = status_r;
    if (wr_go && hit(avs_address, `I2CSR_OFF_STATUS)) begin
      status_nxt = w1c_set(status_r, wbyte0 & `I2CSR_ST_EVT_MASK, 8'h00);
    end
    // Clears by bus conditions come first so that a new event still sets
    if (stop_det) begin
      status_nxt[`I2CSR_ST_STT] = 1'b0;
      status_nxt[`I2CSR_ST_BUSY] = 1'b0;
    end
    if (start_det) begin
      status_nxt[`I2CSR_ST_STP] = 1'b0;
      status_nxt[`I2CSR_ST_NACK] = 1'b0;
      status_nxt[`I2CSR_ST_GC] = 1'b0;
      status_nxt[`I2CSR_ST_STT] = 1'b1;
      status_nxt[`I2CSR_ST_BUSY] = 1'b1;
    end
    if (stop_det) begin
      status_nxt[`I2CSR_ST_STP] = 1'b1;
    end
    if (nack_det) begin
      status_nxt[`I2CSR_ST_NACK] = 1'b1;
    end
    if (gen_call_det) begin
      status_nxt[`I2CSR_ST_GC] = 1'b1;
    end
    if (arb_lost_det) begin
      status_nxt[`I2CSR_ST_ARB] = 1'b1;
    end
    status_nxt[`I2CSR_ST_SCLLOW] = ~scl_sync;
    status_nxt[`I2CSR_ST_UNUSED] = 1'b0;
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= `I2CSR_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxbuf_r <= `I2CSR_RST_BYTE;
    end else if (rx_char_valid) begin
      rxbuf_r <= rx_char_data;
    end
  end

  // A character landing in the read cycle keeps the flag set
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_flag_r <= `I2CSR_RST_RXFLAG;
    end else if (rx_char_valid) begin
      rx_flag_r <= 1'b1;
    end else if (rd_go && hit(avs_address, `I2CSR_OFF_RXBUF)) begin
      rx_flag_r <= 1'b0;
    end else if (wr_go && hit(avs_address, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO) &&
                 wbyte0[`I2CSR_RX_BIT]) begin
      rx_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path

  wire tx_wr;
  assign tx_wr = wr_go & hit(avs_address, `I2CSR_OFF_TXBUF) &
                 avs_byteenable[0];

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txbuf_r <= `I2CSR_RST_BYTE;
      tx_full_r <= 1'b0;
    end else if (tx_wr) begin
      txbuf_r <= avs_writedata[7:0];
      tx_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  // Write beats a simultaneous load: the buffer is full again afterwards
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_flag_r <= `I2CSR_RST_TXFLAG;
    end else if (tx_wr) begin
      tx_flag_r <= 1'b0;
    end else if (tx_load) begin
      tx_flag_r <= 1'b1;
    end else if (wr_go && hit(avs_address, `I2CSR_OFF_SHARED_IRQ_FLAG_TWO) &&
                 wbyte0[`I2CSR_TX_BIT]) begin
      tx_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      taddr_r <= `I2CSR_RST_TADDR;
      evt_en_r <= `I2CSR_RST_EVT_EN;
      ie2_r <= `I2CSR_RST_IE;
      ie1_r <= `I2CSR_RST_IE;
    end else if (wr_go) begin
      if (hit(avs_address, `I2CSR_OFF_TADDR)) begin
        if (avs_byteenable[0]) begin
          taddr_r[7:0] <= wbyte0;
        end
        if (avs_byteenable[1]) begin
          taddr_r[15:8] <= wbyte1 & `I2CSR_TADDR_HI_MASK;
        end
      end
      if (hit(avs_address, `I2CSR_OFF_EVT_EN) && avs_byteenable[0]) begin
        evt_en_r <= wbyte0 & `I2CSR_EVT_EN_MASK;
      end
      if (hit(avs_address, `I2CSR_OFF_IE2) && avs_byteenable[0]) begin
        ie2_r <= wbyte0;
      end
      if (hit(avs_address, `I2CSR_OFF_IE1) && avs_byteenable[0]) begin
        ie1_r <= wbyte0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target address presented to the bus engine

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      taddr_out_r <= 10'h000;
      taddr_valid_r <= 1'b0;
    end else if (!master_mode) begin
      taddr_out_r <= 10'h000;
      taddr_valid_r <= 1'b0;
    end else if (addr_10bit) begin
      taddr_out_r <= taddr_r[`I2CSR_TADDR_MSB:0];
      taddr_valid_r <= 1'b1;
    end else begin
      taddr_out_r <= {3'b000, taddr_r[`I2CSR_TADDR7_MSB:0]};
      taddr_valid_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt
  // Level output, recomputed every cycle; one cycle behind the flags

  always @* begin
    irq_nxt = 1'b0;
    if (|(status_r & evt_en_r & `I2CSR_EVT_EN_MASK)) begin
      irq_nxt = 1'b1;
    end
    if (tx_flag_r & ie2_r[`I2CSR_TX_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (rx_flag_r & ie2_r[`I2CSR_RX_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (|(ie1_flags & ie1_r)) begin
      irq_nxt = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign tx_data = txbuf_r;
  assign tx_pending = tx_full_r;
  assign target_addr_out = taddr_out_r;
  assign target_addr_valid = taddr_valid_r;
  assign irq = irq_r;

endmodule // i2csr_regs

`default_nettype wire

// file: rtl/i2csr_sync.v
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none

module i2csr_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire rstn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  // Resets to the idle high level of a pulled-up line: no false low
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= {WIDTH{1'b1}};
      sync_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // i2csr_sync

`default_nettype wire
